// File: verilog/qwd_pkg.sv
// Package for the quad wiper command decoder: field layout, commands,
// reset values and widths.
// Assumes a single system clock; the serial link is sampled, not clocked.
package qwd_pkg;

	// ------------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------------
	localparam int WORD_BITS  = 16;
	localparam int CMD_MSB    = 15;
	localparam int CMD_LSB    = 12;
	localparam int ADDR_MSB   = 11;
	localparam int ADDR_LSB   = 8;
	localparam int DATA_MSB   = 7;
	localparam int DATA_LSB   = 0;
	localparam int WIPER_BITS = 6;
	localparam int NV_DEPTH   = 16;
	localparam int NV_ABITS   = 4;

	// ------------------------------------------------------------------
	// Values
	// ------------------------------------------------------------------
	localparam logic [5:0] WIPER_ZERO  = 6'h00;
	localparam logic [5:0] WIPER_ONE   = 6'h01;
	localparam logic [5:0] WIPER_MID   = 6'h20;
	localparam logic [5:0] WIPER_FULL  = 6'h3F;
	localparam logic [7:0] NV_WIPER_RESET = 8'h20;
	localparam logic [7:0] NV_OUT_RESET   = 8'h03;
	localparam logic [7:0] NV_USER_RESET  = 8'h00;
	localparam logic [3:0] NV_OUT_ADDR    = 4'h4;

	// ------------------------------------------------------------------
	// Commands
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP       = 4'h0,
		CMD_RESTORE   = 4'h1,
		CMD_SAVE      = 4'h2,
		CMD_NV_WRITE  = 4'h3,
		CMD_SHR_ONE   = 4'h4,
		CMD_SHR_ALL   = 4'h5,
		CMD_DEC_ONE   = 4'h6,
		CMD_DEC_ALL   = 4'h7,
		CMD_RELOAD    = 4'h8,
		CMD_NV_READ   = 4'h9,
		CMD_WIPER_RD  = 4'hA,
		CMD_WIPER_WR  = 4'hB,
		CMD_SHL_ONE   = 4'hC,
		CMD_SHL_ALL   = 4'hD,
		CMD_INC_ONE   = 4'hE,
		CMD_INC_ALL   = 4'hF
	} qwd_cmd_t;

endpackage : qwd_pkg

// File: verilog/qwd_nv_store.sv
// Nonvolatile store model: sixteen bytes, one write port, one registered
// read port and four direct wiper taps plus the output-setting byte.
// Assumes writes are single-cycle; cell programming time is not modelled.
`timescale 1ns/1ps
module qwd_nv_store #(
	parameter int DEPTH = 16,
	parameter int ABITS = 4
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             srst_in,
	// Write port
	input  wire logic             wr_en_in,
	input  wire logic [ABITS-1:0] wr_addr_in,
	input  wire logic [7:0]       wr_data_in,
	// Read port
	input  wire logic [ABITS-1:0] rd_addr_in,
	output logic      [7:0]       rd_data_out,
	// Direct taps
	output logic      [7:0]       tap0_out,
	output logic      [7:0]       tap1_out,
	output logic      [7:0]       tap2_out,
	output logic      [7:0]       tap3_out,
	output logic      [7:0]       tap_cfg_out
);

	logic [7:0] mem_reg [DEPTH];

	// ------------------------------------------------------------------
	// Storage; the reset stands in for factory contents
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_cell
			always_ff @(posedge clk_sys_in) begin
				if (srst_in) begin
					if (gi < 4)
						mem_reg[gi] <= qwd_pkg::NV_WIPER_RESET;
					else if (gi == 4)
						mem_reg[gi] <= qwd_pkg::NV_OUT_RESET;
					else
						mem_reg[gi] <= qwd_pkg::NV_USER_RESET;
				end else if (wr_en_in && wr_addr_in == ABITS'(gi)) begin
					mem_reg[gi] <= wr_data_in;
				end
			end
		end
	endgenerate

	// Registered read
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			rd_data_out <= 8'h00;
		else
			rd_data_out <= mem_reg[rd_addr_in];
	end

	// Taps feed the restore paths directly
	assign tap0_out    = mem_reg[0];
	assign tap1_out    = mem_reg[1];
	assign tap2_out    = mem_reg[2];
	assign tap3_out    = mem_reg[3];
	assign tap_cfg_out = mem_reg[4];

endmodule : qwd_nv_store

// File: verilog/qwd_decoder.sv
// Quad wiper command decoder: serial word capture, command execution on
// chip-select release, four wiper registers and two latched outputs.
// Assumes the serial clock and pins are asynchronous and much slower
// than clk_sys_in (at least four system cycles per serial half period).
`timescale 1ns/1ps
module qwd_decoder #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             srst_in,
	// Serial link (asynchronous pins)
	input  wire logic             spi_clk_in,
	input  wire logic             spi_cs_n_in,
	input  wire logic             serial_input_pin_in,
	output logic                  serial_output_pin_out,
	output logic                  serial_output_pin_oe_out,
	// Control pins (asynchronous)
	input  wire logic             preset_reload_pin_n_in,
	input  wire logic             write_protect_n_in,
	// Device outputs
	output logic      [WIDTH-1:0] wiper0_out,
	output logic      [WIDTH-1:0] wiper1_out,
	output logic      [WIDTH-1:0] wiper2_out,
	output logic      [WIDTH-1:0] wiper3_out,
	output logic                  latched_output_one_out,
	output logic                  latched_output_two_out,
	output logic                  read_power_out
);

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic       sck_d_reg;
	logic       cs_d_reg;
	logic       pr_d_reg;

	// Two flops per pin; stage one is read only by stage two.
	// Reset levels match the idle pins, so no false edge follows reset.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			sync1_reg <= 4'hC;
			sync2_reg <= 4'hC;
		end else begin
			sync1_reg <= {preset_reload_pin_n_in, spi_cs_n_in,
				spi_clk_in, serial_input_pin_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic sdi_s, sck_s, cs_s, pr_s, wp_n_s;
	assign sdi_s = sync2_reg[0];
	assign sck_s = sync2_reg[1];
	assign cs_s  = sync2_reg[2];
	assign pr_s  = sync2_reg[3];

	logic [1:0] wp_sync_reg;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			wp_sync_reg <= 2'h3;
		else
			wp_sync_reg <= {wp_sync_reg[0], write_protect_n_in};
	end
	assign wp_n_s = wp_sync_reg[1];

	// Edge history
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			sck_d_reg <= 1'b0;
			cs_d_reg  <= 1'b1;
			pr_d_reg  <= 1'b1;
		end else begin
			sck_d_reg <= sck_s;
			cs_d_reg  <= cs_s;
			pr_d_reg  <= pr_s;
		end
	end

	logic sck_rise, sck_fall, cs_rise, cs_fall, pr_rise;
	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;
	assign cs_rise  = cs_s & ~cs_d_reg;
	assign cs_fall  = ~cs_s & cs_d_reg;
	assign pr_rise  = pr_s & ~pr_d_reg;

	// ------------------------------------------------------------------
	// Shift register
	// ------------------------------------------------------------------
	logic [15:0] shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic        readback_load;
	logic [7:0]  readback_byte;

	// MSB first, sampled on the rising serial edge; readback load wins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			shift_reg <= 16'h0000;
		end else if (readback_load) begin
			shift_reg <= {shift_reg[15:8], readback_byte};
		end else if (!cs_s && sck_rise) begin
			shift_reg <= {shift_reg[14:0], sdi_s};
		end
	end

	// Count bits per frame so a bare strobe can be told apart
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			bit_cnt_reg <= 5'h00;
		else if (cs_fall)
			bit_cnt_reg <= 5'h00;
		else if (!cs_s && sck_rise && bit_cnt_reg != 5'h1F)
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
	end

	// Output bit changes on the falling edge; open drain style enable
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			serial_output_pin_out <= 1'b0;
		else if (cs_fall || (!cs_s && sck_fall))
			serial_output_pin_out <= shift_reg[15];
	end
	assign serial_output_pin_oe_out = ~cs_s;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	qwd_pkg::qwd_cmd_t cmd, rep_cmd_reg, exe_cmd;
	logic [3:0] addr;
	logic [7:0] data;
	logic       have_word, is_step, exec;
	logic       rep_valid_reg;

	assign cmd  = qwd_pkg::qwd_cmd_t'(shift_reg[qwd_pkg::CMD_MSB:
		qwd_pkg::CMD_LSB]);
	assign addr = shift_reg[qwd_pkg::ADDR_MSB:qwd_pkg::ADDR_LSB];
	assign data = shift_reg[qwd_pkg::DATA_MSB:qwd_pkg::DATA_LSB];
	assign have_word = bit_cnt_reg >= 5'h10;
	assign exec = cs_rise;

	// Step commands: shifts, decrements and increments
	function automatic logic step_cmd(input qwd_pkg::qwd_cmd_t c);
		step_cmd = c inside {qwd_pkg::CMD_SHR_ONE, qwd_pkg::CMD_SHR_ALL,
			qwd_pkg::CMD_DEC_ONE, qwd_pkg::CMD_DEC_ALL,
			qwd_pkg::CMD_SHL_ONE, qwd_pkg::CMD_SHL_ALL,
			qwd_pkg::CMD_INC_ONE, qwd_pkg::CMD_INC_ALL};
	endfunction : step_cmd

	// A strobe with no new word repeats the last full word's command if that was a step command
	assign exe_cmd = have_word ? cmd :
		(rep_valid_reg ? rep_cmd_reg : qwd_pkg::CMD_NOP);
	assign is_step = step_cmd(exe_cmd);

	logic [3:0] rep_addr_reg, exe_addr;
	assign exe_addr = have_word ? addr : rep_addr_reg;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rep_valid_reg <= 1'b0;
			rep_cmd_reg   <= qwd_pkg::CMD_NOP;
			rep_addr_reg  <= 4'h0;
		end else if (exec && have_word) begin
			rep_valid_reg <= step_cmd(cmd);
			rep_cmd_reg   <= cmd;
			rep_addr_reg  <= addr;
		end
	end

	// ------------------------------------------------------------------
	// Nonvolatile store
	// ------------------------------------------------------------------
	logic       nv_wr;
	logic [3:0] nv_wr_addr;
	logic [7:0] nv_wr_data;
	logic [7:0] nv_rd_data;
	logic [7:0] nv_tap [4];
	logic [7:0] nv_cfg;
	logic       rd_pend_reg;
	logic [7:0] wiper_rd_reg;
	logic       rd_is_nv_reg;

	qwd_nv_store #(
		.DEPTH (qwd_pkg::NV_DEPTH),
		.ABITS (qwd_pkg::NV_ABITS)
	) u_store (
		.clk_sys_in  (clk_sys_in),
		.srst_in     (srst_in),
		.wr_en_in    (nv_wr),
		.wr_addr_in  (nv_wr_addr),
		.wr_data_in  (nv_wr_data),
		.rd_addr_in  (exe_addr),
		.rd_data_out (nv_rd_data),
		.tap0_out    (nv_tap[0]),
		.tap1_out    (nv_tap[1]),
		.tap2_out    (nv_tap[2]),
		.tap3_out    (nv_tap[3]),
		.tap_cfg_out (nv_cfg)
	);

	logic [WIDTH-1:0] wiper_reg [4];

	// Save and byte write; the store is not covered by write protect
	always_comb begin
		nv_wr      = 1'b0;
		nv_wr_addr = exe_addr;
		nv_wr_data = data;
		if (exec && have_word) begin
			if (cmd == qwd_pkg::CMD_SAVE) begin
				nv_wr      = 1'b1;
				nv_wr_addr = {2'b00, addr[1:0]};
				nv_wr_data = {2'b00, wiper_reg[addr[1:0]]};
			end else if (cmd == qwd_pkg::CMD_NV_WRITE) begin
				nv_wr = 1'b1;
			end
		end
	end

	// Readback: store read has one cycle latency, so load a cycle later
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rd_pend_reg  <= 1'b0;
			rd_is_nv_reg <= 1'b0;
			wiper_rd_reg <= 8'h00;
		end else begin
			rd_pend_reg  <= exec && have_word &&
				(cmd == qwd_pkg::CMD_NV_READ || cmd == qwd_pkg::CMD_WIPER_RD);
			rd_is_nv_reg <= cmd == qwd_pkg::CMD_NV_READ;
			wiper_rd_reg <= {2'b00, wiper_reg[addr[1:0]]};
		end
	end
	assign readback_load = rd_pend_reg;
	assign readback_byte = rd_is_nv_reg ? nv_rd_data : wiper_rd_reg;

	// ------------------------------------------------------------------
	// Wiper registers
	// ------------------------------------------------------------------
	logic boot_reg;

	// Load from store one cycle after reset release
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			boot_reg <= 1'b1;
		else
			boot_reg <= 1'b0;
	end

	// Saturating step on one value; data byte is never used here
	function automatic logic [WIDTH-1:0] step(input qwd_pkg::qwd_cmd_t c,
		input logic [WIDTH-1:0] v);
		logic [WIDTH-1:0] r;
		r = v;
		unique case (c)
			qwd_pkg::CMD_SHR_ONE, qwd_pkg::CMD_SHR_ALL:
				r = v >> 1;
			qwd_pkg::CMD_DEC_ONE, qwd_pkg::CMD_DEC_ALL:
				r = (v == '0) ? v : v - WIDTH'(1);
			qwd_pkg::CMD_SHL_ONE, qwd_pkg::CMD_SHL_ALL:
				if (v == '0)
					r = WIDTH'(1);
				else if (v[WIDTH-1])
					r = '1;
				else
					r = v << 1;
			qwd_pkg::CMD_INC_ONE, qwd_pkg::CMD_INC_ALL:
				r = (v == '1) ? v : v + WIDTH'(1);
			default:
				r = v;
		endcase
		return r;
	endfunction : step

	logic all_cmd;
	assign all_cmd = exe_cmd inside {qwd_pkg::CMD_SHR_ALL,
		qwd_pkg::CMD_DEC_ALL, qwd_pkg::CMD_SHL_ALL, qwd_pkg::CMD_INC_ALL};

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_wiper
			logic sel;
			assign sel = all_cmd || exe_addr[1:0] == 2'(ch);
			always_ff @(posedge clk_sys_in) begin
				if (srst_in) begin
					wiper_reg[ch] <= qwd_pkg::WIPER_MID;
				end else if (!pr_s) begin
					wiper_reg[ch] <= qwd_pkg::WIPER_MID;
				end else if (boot_reg || pr_rise) begin
					wiper_reg[ch] <= nv_tap[ch][WIDTH-1:0];
				end else if (exec && exe_cmd == qwd_pkg::CMD_RELOAD) begin
					wiper_reg[ch] <= nv_tap[ch][WIDTH-1:0];
				end else if (exec && wp_n_s) begin
					if (exe_cmd == qwd_pkg::CMD_RESTORE && sel)
						wiper_reg[ch] <= nv_tap[ch][WIDTH-1:0];
					else if (exe_cmd == qwd_pkg::CMD_WIPER_WR && sel)
						wiper_reg[ch] <= data[WIDTH-1:0];
					else if (is_step && sel)
						wiper_reg[ch] <= step(exe_cmd, wiper_reg[ch]);
				end
			end
		end
	endgenerate
	// Only six bits of store bytes 0 to 3 reach a wiper

	assign wiper0_out = wiper_reg[0];
	assign wiper1_out = wiper_reg[1];
	assign wiper2_out = wiper_reg[2];
	assign wiper3_out = wiper_reg[3];

	// ------------------------------------------------------------------
	// Latched outputs and power state
	// ------------------------------------------------------------------
	logic [1:0] lat_reg;
	logic       rpow_reg;

	// Reloaded from store byte 4 at boot and by commands 1 and 8
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			lat_reg <= 2'b11;
		else if (boot_reg || (exec && (exe_cmd == qwd_pkg::CMD_RESTORE ||
				exe_cmd == qwd_pkg::CMD_RELOAD)))
			lat_reg <= nv_cfg[1:0];
	end
	assign latched_output_one_out = lat_reg[0];
	assign latched_output_two_out = lat_reg[1];

	// Read power stays on after a restore until a NOP
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			rpow_reg <= 1'b0;
		else if (exec && exe_cmd == qwd_pkg::CMD_RESTORE)
			rpow_reg <= 1'b1;
		else if (exec && have_word && cmd == qwd_pkg::CMD_NOP)
			rpow_reg <= 1'b0;
	end
	assign read_power_out = rpow_reg;

endmodule : qwd_decoder

// File: verification/qwd_spi_master.sv
// Serial master model: drives framed 16-bit words and captures the output.
// Assumes a 200 MHz system clock; the serial clock idles low, mode 0.
`timescale 1ns/1ps
module qwd_spi_master (
	// Clock
	input  wire logic clk_sys_in,
	// Serial link
	output logic      spi_clk_out,
	output logic      spi_cs_n_out,
	output logic      serial_input_pin_out,
	input  wire logic serial_output_pin_in
);
	// Half of a 160 ns serial period
	localparam int HALF = 16;

	// Idle levels; the serial clock stands still between frames
	initial begin
		spi_clk_out = 1'b0;
		spi_cs_n_out = 1'b1;
		serial_input_pin_out = 1'b0;
	end

	// Wait whole system cycles
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : wt

	// One frame of the n low bits of w, MSB first; r gets what came back
	task automatic xfer(input logic [15:0] w, input int n,
			output logic [15:0] r);
		r = 16'h0000;
		spi_cs_n_out <= 1'b0;
		wt(HALF);
		for (int i = n - 1; i >= 0; i--) begin
			serial_input_pin_out <= w[i];
			wt(HALF);
			r = {r[14:0], serial_output_pin_in};
			spi_clk_out <= 1'b1;
			wt(HALF);
			spi_clk_out <= 1'b0;
		end
		wt(HALF);
		spi_cs_n_out <= 1'b1;
		// Data line is not meaningful off-frame, so it toggles
		serial_input_pin_out <= ~serial_input_pin_out;
		wt(HALF);
	endtask : xfer
endmodule : qwd_spi_master

// File: verification/qwd_decoder_sva.sv
// Checker for the quad wiper decoder: timing relations at its pins.
// Assumes serial half periods of many system cycles and frames apart.
`timescale 1ns/1ps
module qwd_decoder_sva #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input wire logic             clk_sys_in,
	input wire logic             srst_in,
	// Serial link
	input wire logic             spi_clk_in,
	input wire logic             spi_cs_n_in,
	input wire logic             serial_input_pin_in,
	input wire logic             serial_output_pin_out,
	input wire logic             serial_output_pin_oe_out,
	// Control pins
	input wire logic             preset_reload_pin_n_in,
	input wire logic             write_protect_n_in,
	// Device outputs
	input wire logic [WIDTH-1:0] wiper0_out,
	input wire logic [WIDTH-1:0] wiper1_out,
	input wire logic [WIDTH-1:0] wiper2_out,
	input wire logic [WIDTH-1:0] wiper3_out,
	input wire logic             latched_output_one_out,
	input wire logic             latched_output_two_out,
	input wire logic             read_power_out
);
	// All four wipers side by side
	logic [4*WIDTH-1:0] wv;
	assign wv = {wiper0_out, wiper1_out, wiper2_out, wiper3_out};

	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);

	chk_oe_frame: assert property (
		$fell(spi_cs_n_in) |-> ##[3:5] serial_output_pin_oe_out)
		else $error("output enable late in frame");
	chk_oe_idle: assert property (
		spi_cs_n_in [*5] |-> !serial_output_pin_oe_out)
		else $error("output enabled outside frame");
	chk_sdo_hold: assert property (
		!spi_cs_n_in && spi_clk_in && $past(spi_clk_in, 4)
		|-> $stable(serial_output_pin_out))
		else $error("serial output moved while clock high");
	chk_reset_vals: assert property (
		$fell(srst_in) |-> wiper0_out == qwd_pkg::WIPER_MID &&
		latched_output_one_out && latched_output_two_out &&
		!read_power_out)
		else $error("wrong values under reset");
	chk_reset_load: assert property (
		$fell(srst_in) |=> wv == {4{qwd_pkg::WIPER_MID}})
		else $error("wipers not loaded from store");
	chk_preset_mid: assert property (
		(!preset_reload_pin_n_in) [*8] |-> wv == {4{qwd_pkg::WIPER_MID}})
		else $error("preset did not force mid-scale");
	chk_power_cs: assert property (
		$changed(read_power_out) |-> spi_cs_n_in && $past(spi_cs_n_in, 2))
		else $error("read power changed inside frame");
	chk_latch_cs: assert property (
		$changed({latched_output_one_out, latched_output_two_out})
		|-> spi_cs_n_in && $past(spi_cs_n_in, 2))
		else $error("latched output changed inside frame");
	chk_wiper_frame: assert property (
		(!spi_cs_n_in && preset_reload_pin_n_in) [*8] |-> $stable(wv))
		else $error("wiper changed before chip select rose");
endmodule : qwd_decoder_sva

bind qwd_decoder qwd_decoder_sva #(.WIDTH(WIDTH)) qwd_decoder_sva_i (
	.clk_sys_in, .srst_in, .spi_clk_in, .spi_cs_n_in, .serial_input_pin_in,
	.serial_output_pin_out, .serial_output_pin_oe_out,
	.preset_reload_pin_n_in, .write_protect_n_in, .wiper0_out, .wiper1_out,
	.wiper2_out, .wiper3_out, .latched_output_one_out,
	.latched_output_two_out, .read_power_out);

// File: verification/qwd_decoder_tb_top.sv
// Testbench for the quad wiper decoder against a reference model.
// Assumes the serial master model and the bound checker are compiled.
`timescale 1ns/1ps
module qwd_decoder_tb_top;
	// ----
	// Signals and reference state
	// ----
	logic clk_sys_in, srst_in, spi_clk_in, spi_cs_n_in, serial_input_pin_in;
	logic serial_output_pin_out, serial_output_pin_oe_out;
	logic preset_reload_pin_n_in, write_protect_n_in, read_power_out;
	logic latched_output_one_out, latched_output_two_out;
	logic [5:0] wiper0_out, wiper1_out, wiper2_out, wiper3_out;
	logic [15:0] rx;
	int mismatches, checks, srv, rep, repa, sr, mlo1, mlo2, mrp;
	int wm[4];
	int nv[16];
	int dir[$] = '{16'hB000, 16'hC000, 16'hB120, 16'hC100, 16'hE100,
		16'h4100, 16'hB23F, 16'h4200, 16'hB300, 16'h6300, 16'h7000,
		16'hF000, 16'h5000, 16'hD000, 16'h3402, 16'h8000, 16'h2100,
		16'h9100, 16'hA200, 16'h0000};
	int wpc[$] = '{11, 14, 13, 6, 8, 0};
	// Open-drain output line with its pull-up
	wire sdo_line = serial_output_pin_oe_out ? serial_output_pin_out : 1'b1;

	qwd_decoder #(.WIDTH(6)) qwd_decoder_i (.clk_sys_in, .srst_in,
		.spi_clk_in, .spi_cs_n_in, .serial_input_pin_in,
		.serial_output_pin_out, .serial_output_pin_oe_out,
		.preset_reload_pin_n_in, .write_protect_n_in, .wiper0_out,
		.wiper1_out, .wiper2_out, .wiper3_out, .latched_output_one_out,
		.latched_output_two_out, .read_power_out);
	qwd_spi_master qwd_spi_master_i (.clk_sys_in, .spi_clk_out(spi_clk_in),
		.spi_cs_n_out(spi_cs_n_in), .serial_input_pin_out(serial_input_pin_in),
		.serial_output_pin_in(sdo_line));

	// ----
	// Helpers
	// ----
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] seen, input int exp);
		checks++;
		if (seen !== 16'(exp)) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, 16'(exp));
		end
	endtask : chk

	task automatic chk_state();
		chk(16'(wiper0_out), wm[0]);
		chk(16'(wiper1_out), wm[1]);
		chk(16'(wiper2_out), wm[2]);
		chk(16'(wiper3_out), wm[3]);
		chk(16'(latched_output_one_out), mlo1);
		chk(16'(latched_output_two_out), mlo2);
		chk(16'(read_power_out), mrp);
	endtask : chk_state

	// Saturating step of one wiper; upper three command bits pick the kind
	function automatic int step(input int c, input int v);
		case (c[3:1])
			3'h2: return v >> 1;
			3'h3: return v > 0 ? v - 1 : 0;
			3'h6: return v == 0 ? 1 : (v >= 32 ? 63 : v << 1);
			default: return v < 63 ? v + 1 : 63;
		endcase
	endfunction : step

	// Reference execution of one command
	task automatic exe(input int c, input int a, input int d);
		int b;
		b = a & 3;
		if (c inside {[4:7], [12:15]})
			for (int i = 0; i < 4; i++)
				if (write_protect_n_in && (c[0] || i == b))
					wm[i] = step(c, wm[i]);
		case (c)
			0: mrp = 0;
			1: begin
				if (write_protect_n_in)
					wm[b] = nv[b] & 8'h3F;
				mrp = 1;
			end
			2: nv[b] = wm[b];
			3: nv[a] = d;
			8: for (int i = 0; i < 4; i++)
				wm[i] = nv[i] & 8'h3F;
			9: sr = (sr & 16'hFF00) | nv[a];
			10: sr = (sr & 16'hFF00) | wm[b];
			11: if (write_protect_n_in) wm[b] = d & 8'h3F;
			default: ;
		endcase
		if (c == 1 || c == 8) begin
			mlo1 = nv[4] & 1;
			mlo2 = nv[4] >> 1 & 1;
		end
	endtask : exe

	// One frame of n bits; a short one is a bare strobe
	task automatic frame(input int c, input int a, input int d, input int n);
		logic [15:0] wd;
		int old;
		wd = {c[3:0], a[3:0], d[7:0]};
		old = sr;
		qwd_spi_master_i.xfer(wd, n, rx);
		sr = ((sr << n) | (wd & ((1 << n) - 1))) & 16'hFFFF;
		if (n == 16) begin
			if (srv) chk(rx, old);
			srv = 1;
			exe(c, a, d);
			rep = c inside {[4:7], [12:15]} ? c : -1;
			repa = a;
		end else if (rep >= 0)
			exe(rep, repa, 0);
		chk_state();
	endtask : frame

	task automatic rnd(input int c);
		int a;
		a = (c == 3 || c == 9) ? $urandom % 16 : $urandom % 4;
		frame(c, a, $urandom % 256, 16);
		if (c == 1)
			frame(0, 0, 0, 16);
	endtask : rnd

	// Preset low forces mid-scale, its release reloads the wipers from the store
	task automatic preset();
		preset_reload_pin_n_in <= 1'b0;
		repeat (12) @(posedge clk_sys_in);
		foreach (wm[i]) wm[i] = 32;
		chk_state();
		preset_reload_pin_n_in <= 1'b1;
		repeat (12) @(posedge clk_sys_in);
		foreach (wm[i]) wm[i] = nv[i] & 8'h3F;
		chk_state();
	endtask : preset

	// Reset pulse with the reference brought back to factory state
	task automatic restart();
		srst_in <= 1'b1;
		foreach (nv[i]) nv[i] = i < 4 ? 32 : (i == 4 ? 3 : 0);
		foreach (wm[i]) wm[i] = 32;
		mlo1 = 1;
		mlo2 = 1;
		mrp = 0;
		sr = 0;
		srv = 0;
		rep = -1;
		repeat (3) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		chk_state();
	endtask : restart

	// ----
	// Clock, watchdog and main sequence
	// ----
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	// Cuts a hang short
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		mismatches++;
		stop_test();
	end

	initial begin
		srst_in = 1'b1;
		preset_reload_pin_n_in = 1'b1;
		write_protect_n_in = 1'b1;
		void'($urandom(6659));
		restart();
		for (int c = 0; c < 16; c++)
			rnd(c);
		foreach (dir[k])
			frame(dir[k] >> 12, dir[k] >> 8 & 15, dir[k] & 255, 16);
		// Bare strobes repeat a step until a full other word cancels it
		frame(14, 2, 8'hA5, 16);
		repeat (2) frame(0, 0, 0, 0);
		frame(0, 0, 0, 5);
		frame(0, 0, 0, 16);
		frame(0, 0, 0, 0);
		write_protect_n_in <= 1'b0;
		foreach (wpc[k])
			rnd(wpc[k]);
		write_protect_n_in <= 1'b1;
		preset();
		// Mid-run reset after user changes brings back factory state
		restart();
		repeat (40) rnd($urandom % 16);
		stop_test();
	end
endmodule : qwd_decoder_tb_top
